// >>> rtc_pkg.sv
package rtc_pkg;

   // ************************************************************
   // Register byte addresses (one aligned word each)
   // ************************************************************
   localparam logic [5:0] ADDR_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_BYTE_ONE = 6'h04;
   localparam logic [5:0] ADDR_BYTE_TWO = 6'h08;
   localparam logic [5:0] ADDR_BYTE_THREE = 6'h0c;
   localparam logic [5:0] ADDR_BYTE_FOUR = 6'h10;
   localparam logic [5:0] ADDR_MONTH_DAY = 6'h14;
   localparam logic [5:0] ADDR_MONTH = 6'h18;
   localparam logic [5:0] ADDR_YEAR_LOW = 6'h1c;
   localparam logic [5:0] ADDR_YEAR_HIGH = 6'h20;
   localparam logic [5:0] ADDR_IE_TWO = 6'h24;
   localparam logic [5:0] ADDR_IFG_TWO = 6'h28;
   localparam logic [5:0] ADDR_SERVICE = 6'h2c;

   // ************************************************************
   // Control field positions and reset values
   // ************************************************************
   localparam int BIT_DECIMAL = 7;
   localparam int BIT_HOLD = 6;
   localparam int BIT_MODE_LO = 4;
   localparam int BIT_EVENT_LO = 2;
   localparam int BIT_IRQ_EN = 1;
   localparam int BIT_FLAG = 0;
   localparam int BIT_SHARED = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h40;
   localparam logic [7:0] IE_TWO_RESET = 8'h00;
   localparam logic [7:0] IFG_TWO_RESET = 8'h00;
   localparam logic [7:0] DAY_ONE = 8'h01;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ************************************************************
   // Modes and bus states
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_CNT_AUX = 2'b00,
      MODE_CNT_TAP = 2'b01,
      MODE_CNT_SUB = 2'b10,
      MODE_CALENDAR = 2'b11
   } clock_mode_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_ANSWER = 2'b01
   } bus_state_t;

   // Avalon request bundle
   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } avalon_req_t;

   // Avalon answer bundle
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avalon_rsp_t;

endpackage

// >>> rtc_calendar_counter.sv
// Added by the designer: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Hold stops clock; calendar also stops prescaler
// - Mode field selects source and calendar
// - Counter events at byte overflow boundaries
// - Calendar events minute, hour, midnight, noon
// - Control bit 1 enables clock interrupt
// - Control bit 0 is event flag
// - Four count bytes readable and writable
// - BCD minutes: bit7 zero, tens, units
// - Hours upper bits zero, hex or BCD
// - Weekday 0 to 6, upper bits zero
// - Month day 1..31, upper bits zero
// - Month 1..12, upper bits zero
// - Year high nibble hex or century BCD
// - Enable-two bit 7 gates shared flag
// - Shared flag pends, clears on service
// - Enabled event sets both flags, requests interrupt
// - Entering calendar resets time, day/month one
// - Years divisible by four are leap
// - Four bytes cascade into one 32-bit count
module rtc_calendar_counter (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Count clock sources (asynchronous levels)
   input wire logic aux_clock_in,
   input wire logic prescaler_tap_in,
   input wire logic subsystem_clock_in,
   // Avalon-MM slave
   input wire rtc_pkg::avalon_req_t avs_req_in,
   output rtc_pkg::avalon_rsp_t avs_rsp_out,
   // Status
   output logic prescaler_stop_out,
   output logic irq_request_out
);
   import rtc_pkg::*;

   // ************************************************************
   // Helper functions
   // ************************************************************
   // Increment one digit field, hex or BCD
   function automatic logic [7:0] step(input logic [7:0] v, input logic bcd);
      if (bcd && v[3:0] == 4'h9) begin
         step = {v[7:4] + 4'h1, 4'h0};
      end else begin
         step = v + 8'h01;
      end
   endfunction

   // Compare a field to a small number, hex or BCD
   function automatic logic is_val(input logic [7:0] v, input logic bcd,
                                   input logic [7:0] n);
      logic [7:0] enc;
      enc = bcd ? (((n / 8'd10) << 4) | (n % 8'd10)) : n;
      is_val = (v == enc);
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   logic [7:0] control_ff;
   logic [7:0] cnt_ff [4];  // Seconds, minutes, hours, weekday in calendar
   logic [7:0] mday_ff, month_ff, year_lo_ff, year_hi_ff;
   logic [7:0] ie_two_ff, ifg_two_ff;
   logic [2:0] sync_aux_ff, sync_tap_ff, sync_sub_ff;
   avalon_rsp_t rsp_ff;
   bus_state_t bus_ff;
   logic prescaler_stop_ff, irq_ff;

   clock_mode_t mode;
   logic bcd, hold, tick, wr_en, rd_en, service;
   logic [31:0] count_now;
   logic cal_sec_wrap, cal_min_wrap, cal_hour_wrap, cal_day_wrap, cal_mon_wrap;
   logic [7:0] last_day;
   logic event_hit;
   logic enter_cal;

   assign mode = clock_mode_t'(control_ff[BIT_MODE_LO +: 2]);
   assign bcd = control_ff[BIT_DECIMAL];
   assign hold = control_ff[BIT_HOLD];

   // ************************************************************
   // Source synchronisers and edge detection
   // ************************************************************
   // Stage 0 feeds stage 1 only; edge taken from stages 1 and 2
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sync_aux_ff <= 3'h0;
         sync_tap_ff <= 3'h0;
         sync_sub_ff <= 3'h0;
      end else begin
         sync_aux_ff <= {sync_aux_ff[1:0], aux_clock_in};
         sync_tap_ff <= {sync_tap_ff[1:0], prescaler_tap_in};
         sync_sub_ff <= {sync_sub_ff[1:0], subsystem_clock_in};
      end
   end

   // Rising edge of the selected source, blocked by hold or write
   always_comb begin
      case (mode)
         MODE_CNT_AUX: tick = sync_aux_ff[1] & ~sync_aux_ff[2];
         MODE_CNT_TAP: tick = sync_tap_ff[1] & ~sync_tap_ff[2];
         MODE_CNT_SUB: tick = sync_sub_ff[1] & ~sync_sub_ff[2];
         MODE_CALENDAR: tick = sync_tap_ff[1] & ~sync_tap_ff[2];
         default: tick = 1'b0;
      endcase
      tick = tick & ~hold & ~wr_en;
   end

   // ************************************************************
   // Calendar rollover decode
   // ************************************************************
   always_comb begin
      if (is_val(month_ff, bcd, 8'd2)) begin
         // BCD: odd tens need units 2 or 6, even tens need 0, 4 or 8
         if (bcd) begin
            last_day = (year_lo_ff[4] ?
                        (year_lo_ff[3:0] == 4'h2 || year_lo_ff[3:0] == 4'h6) :
                        (year_lo_ff[3:0] == 4'h0 || year_lo_ff[3:0] == 4'h4 ||
                         year_lo_ff[3:0] == 4'h8)) ? 8'd29 : 8'd28;
         end else begin
            last_day = (year_lo_ff[1:0] == 2'b00) ? 8'd29 : 8'd28;
         end
      end else if (is_val(month_ff, bcd, 8'd4) || is_val(month_ff, bcd, 8'd6) ||
                   is_val(month_ff, bcd, 8'd9) || is_val(month_ff, bcd, 8'd11)) begin
         last_day = 8'd30;
      end else begin
         last_day = 8'd31;
      end
      cal_sec_wrap = is_val(cnt_ff[0], bcd, 8'd59);
      cal_min_wrap = cal_sec_wrap & is_val(cnt_ff[1], bcd, 8'd59);
      cal_hour_wrap = cal_min_wrap & is_val(cnt_ff[2], bcd, 8'd23);
      cal_day_wrap = cal_hour_wrap & is_val(mday_ff, bcd, last_day);
      cal_mon_wrap = cal_day_wrap & is_val(month_ff, bcd, 8'd12);
   end

   // ************************************************************
   // Time event selection
   // ************************************************************
   assign count_now = {cnt_ff[3], cnt_ff[2], cnt_ff[1], cnt_ff[0]};
   always_comb begin
      event_hit = 1'b0;
      if (tick) begin
         if (mode == MODE_CALENDAR) begin
            case (control_ff[BIT_EVENT_LO +: 2])
               2'b00: event_hit = cal_sec_wrap;
               2'b01: event_hit = cal_min_wrap;
               2'b10: event_hit = cal_hour_wrap;
               2'b11: event_hit = cal_min_wrap & is_val(cnt_ff[2], bcd, 8'd11);
               default: event_hit = 1'b0;
            endcase
         end else begin
            case (control_ff[BIT_EVENT_LO +: 2])
               2'b00: event_hit = &count_now[7:0];
               2'b01: event_hit = &count_now[15:0];
               2'b10: event_hit = &count_now[23:0];
               2'b11: event_hit = &count_now;
               default: event_hit = 1'b0;
            endcase
         end
      end
   end

   // ************************************************************
   // Bus decode
   // ************************************************************
   assign wr_en = avs_req_in.write & (bus_ff == BUS_IDLE);
   assign rd_en = avs_req_in.read & (bus_ff == BUS_IDLE);
   assign service = wr_en & (avs_req_in.address == ADDR_SERVICE);
   assign enter_cal = wr_en && avs_req_in.address == ADDR_CONTROL &&
                      ((avs_req_in.writedata[BIT_MODE_LO +: 2] == 2'b11 &&
                        mode != MODE_CALENDAR) ||
                       (avs_req_in.writedata[BIT_DECIMAL] != bcd));

   // ************************************************************
   // Control register and flags
   // ************************************************************
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         control_ff <= CONTROL_RESET;
      end else begin
         if (wr_en && avs_req_in.address == ADDR_CONTROL) begin
            control_ff <= avs_req_in.writedata[7:0];
         end
         if (event_hit) begin
            control_ff[BIT_FLAG] <= 1'b1;
         end else if (service && control_ff[BIT_IRQ_EN]) begin
            control_ff[BIT_FLAG] <= 1'b0;
         end
      end
   end

   // Shared enable and flag registers
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         ie_two_ff <= IE_TWO_RESET;
         ifg_two_ff <= IFG_TWO_RESET;
      end else begin
         if (wr_en && avs_req_in.address == ADDR_IE_TWO) begin
            ie_two_ff <= avs_req_in.writedata[7:0];
         end
         if (wr_en && avs_req_in.address == ADDR_IFG_TWO) begin
            ifg_two_ff <= avs_req_in.writedata[7:0];
         end else if (service) begin
            ifg_two_ff[BIT_SHARED] <= 1'b0;
         end
         if (event_hit && control_ff[BIT_IRQ_EN]) begin
            ifg_two_ff[BIT_SHARED] <= 1'b1;
         end
      end
   end

   // Interrupt request and prescaler stop outputs
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_ff <= 1'b0;
         prescaler_stop_ff <= 1'b0;
      end else begin
         irq_ff <= ifg_two_ff[BIT_SHARED] & ie_two_ff[BIT_SHARED];
         prescaler_stop_ff <= hold & (mode == MODE_CALENDAR);
      end
   end

   // ************************************************************
   // Counter and calendar fields (not reset by hardware)
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (enter_cal) begin
         for (int i = 0; i < 4; i++) begin
            cnt_ff[i] <= ZERO_BYTE;
         end
         mday_ff <= DAY_ONE;
         month_ff <= DAY_ONE;
         year_lo_ff <= ZERO_BYTE;
         year_hi_ff <= ZERO_BYTE;
      end else if (wr_en) begin
         case (avs_req_in.address)
            ADDR_BYTE_ONE: cnt_ff[0] <= avs_req_in.writedata[7:0];
            ADDR_BYTE_TWO: cnt_ff[1] <= avs_req_in.writedata[7:0];
            ADDR_BYTE_THREE: cnt_ff[2] <= avs_req_in.writedata[7:0];
            ADDR_BYTE_FOUR: cnt_ff[3] <= avs_req_in.writedata[7:0];
            ADDR_MONTH_DAY: mday_ff <= avs_req_in.writedata[7:0];
            ADDR_MONTH: month_ff <= avs_req_in.writedata[7:0];
            ADDR_YEAR_LOW: year_lo_ff <= avs_req_in.writedata[7:0];
            ADDR_YEAR_HIGH: year_hi_ff <= avs_req_in.writedata[7:0];
            default: ;
         endcase
      end else if (tick && mode != MODE_CALENDAR) begin
         {cnt_ff[3], cnt_ff[2], cnt_ff[1], cnt_ff[0]} <= count_now + 32'h1;
      end else if (tick) begin
         cnt_ff[0] <= cal_sec_wrap ? ZERO_BYTE : step(cnt_ff[0], bcd);
         if (cal_sec_wrap) begin
            cnt_ff[1] <= cal_min_wrap ? ZERO_BYTE : step(cnt_ff[1], bcd);
         end
         if (cal_min_wrap) begin
            cnt_ff[2] <= cal_hour_wrap ? ZERO_BYTE : step(cnt_ff[2], bcd);
         end
         if (cal_hour_wrap) begin
            cnt_ff[3] <= (cnt_ff[3][2:0] == 3'h6) ? ZERO_BYTE : cnt_ff[3] + 8'h01;
            mday_ff <= cal_day_wrap ? DAY_ONE : step(mday_ff, bcd);
         end
         if (cal_day_wrap) begin
            month_ff <= cal_mon_wrap ? DAY_ONE : step(month_ff, bcd);
         end
         if (cal_mon_wrap) begin
            if ((bcd && is_val(year_lo_ff, bcd, 8'd99)) || (!bcd && year_lo_ff == 8'hff)) begin
               year_lo_ff <= ZERO_BYTE;
               year_hi_ff <= step(year_hi_ff, bcd);
            end else begin
               year_lo_ff <= step(year_lo_ff, bcd);
            end
         end
      end
   end

   // ************************************************************
   // Avalon slave: one wait cycle, then answer
   // ************************************************************
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         bus_ff <= BUS_IDLE;
         rsp_ff <= '{readdata: 32'h0, waitrequest: 1'b1};
      end else begin
         rsp_ff.waitrequest <= 1'b1;
         if (bus_ff == BUS_ANSWER) begin
            bus_ff <= BUS_IDLE;
         end else if (rd_en || wr_en) begin
            bus_ff <= BUS_ANSWER;
            rsp_ff.waitrequest <= 1'b0;
            rsp_ff.readdata <= 32'h0;
            if (rd_en) begin
               case (avs_req_in.address)
                  ADDR_CONTROL: rsp_ff.readdata[7:0] <= control_ff;
                  ADDR_BYTE_ONE: rsp_ff.readdata[7:0] <= cnt_ff[0] &
                     ((mode == MODE_CALENDAR) ? 8'h7f : 8'hff);
                  ADDR_BYTE_TWO: rsp_ff.readdata[7:0] <= cnt_ff[1] &
                     ((mode == MODE_CALENDAR) ? 8'h7f : 8'hff);
                  ADDR_BYTE_THREE: rsp_ff.readdata[7:0] <= cnt_ff[2] &
                     ((mode != MODE_CALENDAR) ? 8'hff : bcd ? 8'h3f : 8'h1f);
                  ADDR_BYTE_FOUR: rsp_ff.readdata[7:0] <= cnt_ff[3] &
                     ((mode == MODE_CALENDAR) ? 8'h07 : 8'hff);
                  ADDR_MONTH_DAY: rsp_ff.readdata[7:0] <= mday_ff &
                     (bcd ? 8'h3f : 8'h1f);
                  ADDR_MONTH: rsp_ff.readdata[7:0] <= month_ff &
                     (bcd ? 8'h1f : 8'h0f);
                  ADDR_YEAR_LOW: rsp_ff.readdata[7:0] <= year_lo_ff;
                  ADDR_YEAR_HIGH: rsp_ff.readdata[7:0] <= year_hi_ff &
                     (bcd ? 8'h7f : 8'h0f);
                  ADDR_IE_TWO: rsp_ff.readdata[7:0] <= ie_two_ff;
                  ADDR_IFG_TWO: rsp_ff.readdata[7:0] <= ifg_two_ff;
                  default: rsp_ff.readdata <= 32'h0;
               endcase
            end
         end
      end
   end

   assign avs_rsp_out = rsp_ff;
   assign irq_request_out = irq_ff;
   assign prescaler_stop_out = prescaler_stop_ff;

endmodule // rtc_calendar_counter

// >>> rtc_calendar_counter_properties.sv
`timescale 1ns/1ps
// ************************************************************
// Port checker
// ************************************************************
module rtc_calendar_counter_properties (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Bus and status
   input wire rtc_pkg::avalon_req_t avs_req_in,
   input wire rtc_pkg::avalon_rsp_t avs_rsp_out,
   input wire logic prescaler_stop_out,
   input wire logic irq_request_out
);
   import rtc_pkg::*;
   logic fin;
   logic wfin;
   logic rfin;

   // Access completion strobes
   assign fin = !avs_rsp_out.waitrequest;
   assign wfin = fin && avs_req_in.write;
   assign rfin = fin && avs_req_in.read;

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);

   AST_WAIT_ONE: assert property (fin |=> !fin)
      else $error("waitrequest low longer than one cycle");
   AST_ANSWER: assert property ($rose(avs_req_in.read || avs_req_in.write) |-> ##[1:3] fin)
      else $error("request not answered in time");
   AST_NO_SPURIOUS: assert property (fin |-> avs_req_in.read || avs_req_in.write)
      else $error("answer without a request");
   AST_UPPER_ZERO: assert property (rfin |-> avs_rsp_out.readdata[31:8] == 24'h000000)
      else $error("read data upper bits not zero");
   AST_MONTH_BITS: assert property (rfin && avs_req_in.address == ADDR_MONTH
      |-> avs_rsp_out.readdata[7:5] == 3'h0)
      else $error("month upper bits not zero");
   AST_DAY_BITS: assert property (rfin && avs_req_in.address == ADDR_MONTH_DAY
      |-> avs_rsp_out.readdata[7:6] == 2'h0)
      else $error("month day upper bits not zero");
   AST_YEARH_BIT: assert property (rfin && avs_req_in.address == ADDR_YEAR_HIGH
      |-> !avs_rsp_out.readdata[7])
      else $error("year high bit 7 not zero");
   AST_STOP_ON: assert property (wfin && avs_req_in.address == ADDR_CONTROL
      && avs_req_in.writedata[6] && avs_req_in.writedata[5:4] == 2'h3
      |-> ##[0:2] prescaler_stop_out)
      else $error("prescaler not stopped by calendar hold");
   AST_STOP_OFF: assert property (wfin && avs_req_in.address == ADDR_CONTROL
      && !avs_req_in.writedata[6] |-> ##[0:2] !prescaler_stop_out)
      else $error("prescaler stopped while running");
   AST_IE_OFF: assert property (wfin && avs_req_in.address == ADDR_IE_TWO
      && !avs_req_in.writedata[7] |-> ##[1:2] !irq_request_out)
      else $error("interrupt request while disabled");
   AST_SERVICE: assert property (wfin && avs_req_in.address == ADDR_SERVICE
      |-> ##[1:2] !irq_request_out)
      else $error("interrupt request after service");
   AST_RESET_IDLE: assert property ($rose(resetn_in)
      |-> avs_rsp_out.waitrequest && !irq_request_out && !prescaler_stop_out)
      else $error("outputs not idle after reset");
endmodule // rtc_calendar_counter_properties

// >>> rtc_calendar_counter_tb.sv
`timescale 1ns/1ps
module rtc_calendar_counter_tb;
   import rtc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] src = 3'h0;
   avalon_req_t rq = '0;
   avalon_rsp_t rs;
   logic stop;
   logic irq;
   logic [7:0] d;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   // ************************************************************
   // Clock, design and timeout
   // ************************************************************
   initial begin
      forever #20 clk = ~clk;
   end

   rtc_calendar_counter u_rtc_calendar_counter (
      .mclk_in(clk), .resetn_in(rst_n), .aux_clock_in(src[0]), .prescaler_tap_in(src[1]),
      .subsystem_clock_in(src[2]), .avs_req_in(rq), .avs_rsp_out(rs),
      .prescaler_stop_out(stop), .irq_request_out(irq));

   // Cycle ceiling
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: byte %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk1(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: flag %b expected %b", $time, g, e);
      end
   endtask

   // One bus access, held until waitrequest is seen low
   task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] v);
      rq.address <= a;
      rq.read <= !w;
      rq.write <= w;
      rq.writedata <= {24'h000000, v};
      do @(posedge clk); while (rs.waitrequest !== 1'b0);
      d = rs.readdata[7:0];
      rq.read <= 1'b0;
      rq.write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      bus(a, 1'b1, v);
   endtask

   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      chk8(d, e);
   endtask

   // Count source pulse, high four cycles, then low six cycles
   task automatic pulse(input logic [2:0] m);
      src <= m;
      repeat (4) @(posedge clk);
      src <= 3'h0;
      repeat (6) @(posedge clk);
   endtask

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      int k;
      int e;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rc(ADDR_CONTROL, CONTROL_RESET);
      rc(ADDR_IE_TWO, IE_TWO_RESET);
      rc(ADDR_IFG_TWO, IFG_TWO_RESET);
      wr(6'h30, 8'h5a);
      rc(6'h30, 8'h00);
      for (k = 0; k < 4; k++) wr(ADDR_BYTE_ONE + 6'(4 * k), 8'(8'h11 * (k + 1)));
      for (k = 0; k < 4; k++) rc(ADDR_BYTE_ONE + 6'(4 * k), 8'(8'h11 * (k + 1)));
      $display("Test reset and bytes done");
      // Each counter source counted alone, then held
      for (e = 0; e < 3; e++) begin
         wr(ADDR_BYTE_ONE, 8'h00);
         wr(ADDR_CONTROL, 8'(e << 4));
         for (k = 0; k < 3; k++) pulse(3'(1 << k));
         wr(ADDR_CONTROL, 8'(8'h40 | e << 4));
         pulse(3'h7);
         rc(ADDR_BYTE_ONE, 8'h01);
      end
      $display("Test sources done");
      // Overflow events per byte, shy by one then reached
      for (e = 0; e < 4; e++) begin
         wr(ADDR_CONTROL, 8'(8'h40 | e << 2));
         for (k = 0; k < 4; k++) wr(ADDR_BYTE_ONE + 6'(4 * k), (k < e) ? 8'hff : 8'h00);
         wr(ADDR_CONTROL, 8'(e << 2));
         pulse(3'h1);
         rc(ADDR_CONTROL, 8'(e << 2));
         rc(ADDR_BYTE_ONE + 6'(4 * e), 8'h01);
         wr(ADDR_CONTROL, 8'(8'h40 | e << 2));
         for (k = 0; k <= e; k++) wr(ADDR_BYTE_ONE + 6'(4 * k), 8'hff);
         wr(ADDR_CONTROL, 8'(e << 2));
         pulse(3'h1);
         rc(ADDR_CONTROL, 8'(e << 2 | 1));
         rc(ADDR_IFG_TWO, 8'h00);
      end
      $display("Test counter events done");
      wr(ADDR_CONTROL, 8'h40);
      wr(ADDR_BYTE_ONE, 8'hff);
      wr(ADDR_IE_TWO, 8'h80);
      wr(ADDR_CONTROL, 8'h02);
      pulse(3'h1);
      rc(ADDR_CONTROL, 8'h03);
      rc(ADDR_IFG_TWO, 8'h80);
      chk1(irq, 1'b1);
      wr(ADDR_IE_TWO, 8'h00);
      chk1(irq, 1'b0);
      wr(ADDR_IE_TWO, 8'h80);
      chk1(irq, 1'b1);
      wr(ADDR_SERVICE, 8'h00);
      chk1(irq, 1'b0);
      rc(ADDR_IFG_TWO, 8'h00);
      rc(ADDR_CONTROL, 8'h02);
      $display("Test interrupt done");
      wr(ADDR_CONTROL, 8'h70);
      chk1(stop, 1'b1);
      for (k = 0; k < 4; k++) rc(ADDR_BYTE_ONE + 6'(4 * k), 8'h00);
      rc(ADDR_MONTH_DAY, DAY_ONE);
      rc(ADDR_MONTH, DAY_ONE);
      rc(ADDR_YEAR_LOW, 8'h00);
      wr(ADDR_BYTE_ONE, 8'h3b);
      wr(ADDR_BYTE_TWO, 8'h3b);
      wr(ADDR_CONTROL, 8'h30);
      chk1(stop, 1'b0);
      pulse(3'h2);
      rc(ADDR_BYTE_TWO, 8'h00);
      rc(ADDR_BYTE_THREE, 8'h01);
      rc(ADDR_CONTROL, 8'h31);
      $display("Test hex calendar done");
      wr(ADDR_CONTROL, 8'hf0);
      rc(ADDR_BYTE_THREE, 8'h00);
      wr(ADDR_MONTH_DAY, 8'h28);
      wr(ADDR_MONTH, 8'h02);
      wr(ADDR_YEAR_LOW, 8'h24);
      // Hour change, midnight and noon in decimal format
      for (e = 1; e < 4; e++) begin
         wr(ADDR_CONTROL, 8'(8'hf0 | e << 2));
         wr(ADDR_BYTE_ONE, 8'h59);
         wr(ADDR_BYTE_TWO, 8'h59);
         wr(ADDR_BYTE_THREE, (e == 1) ? 8'h05 : (e == 2) ? 8'h23 : 8'h11);
         wr(ADDR_CONTROL, 8'(8'hb0 | e << 2));
         pulse(3'h2);
         rc(ADDR_CONTROL, 8'(8'hb1 | e << 2));
      end
      rc(ADDR_BYTE_THREE, 8'h12);
      rc(ADDR_BYTE_FOUR, 8'h01);
      rc(ADDR_MONTH_DAY, 8'h29);
      rc(ADDR_MONTH, 8'h02);
      rc(ADDR_YEAR_HIGH, 8'h00);
      // Leap year with odd tens digit in decimal format
      wr(ADDR_CONTROL, 8'hfc);
      wr(ADDR_YEAR_LOW, 8'h12);
      wr(ADDR_MONTH_DAY, 8'h28);
      wr(ADDR_BYTE_ONE, 8'h59);
      wr(ADDR_BYTE_TWO, 8'h59);
      wr(ADDR_BYTE_THREE, 8'h23);
      wr(ADDR_CONTROL, 8'hbc);
      pulse(3'h2);
      rc(ADDR_MONTH_DAY, 8'h29);
      $display("Test decimal calendar done");
      report_and_stop();
   end
endmodule // rtc_calendar_counter_tb

bind rtc_calendar_counter rtc_calendar_counter_properties u_rtc_calendar_counter_properties (
   .mclk_in(mclk_in), .resetn_in(resetn_in), .avs_req_in(avs_req_in),
   .avs_rsp_out(avs_rsp_out), .prescaler_stop_out(prescaler_stop_out),
   .irq_request_out(irq_request_out));
